// [tb/asb_mem.sv]
// Behavioural model of the byte-lane static memory
`timescale 1ns/1ns
`default_nettype none
module asb_mem
	import asb_pkg::*;
(
	input wire asb_pins_s pins,
	input wire logic [DATA_W-1:0] dq,
	output logic [DATA_W-1:0] q
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic [DATA_W-1:0] rd;
	logic [1:0] on;
	logic wr_on;
	logic rd_on;
	// Write window is the overlap of select and strobe
	assign wr_on = !pins.chip_select_n && !pins.write_strobe_n;
	assign rd_on = !pins.chip_select_n && pins.write_strobe_n &&
		!pins.output_enable_n;
	// Sampled just inside the window so the data has settled
	always @(posedge wr_on) begin
		#1;
		if (!pins.low_lane_select_n) mem[pins.addr][7:0] = dq[7:0];
		if (!pins.high_lane_select_n) mem[pins.addr][15:8] = dq[15:8];
	end
	// Access delays of the slowest grade
	assign #(ADDR_ACCESS_TIME_NS) rd = mem[pins.addr];
	assign #(LANE_ACCESS_NS) on = {2{rd_on}} &
		~{pins.high_lane_select_n, pins.low_lane_select_n};
	// Floating lanes show the inverse, never a kind value
	assign q = {on[1] ? rd[15:8] : ~rd[15:8], on[0] ? rd[7:0] : ~rd[7:0]};
endmodule
`default_nettype wire

// [tb/asb_props.sv]
// Checker on the host controller ports
`timescale 1ns/1ns
`default_nettype none
module asb_props
	import asb_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire logic retention_req,
	input wire logic retention_ok,
	input wire asb_pins_s pins,
	input wire logic [DATA_W-1:0] dq_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wr_in_cs_a: assert property (!pins.write_strobe_n |->
		!pins.chip_select_n) else $error("strobe outside select");
	rd_we_high_a: assert property (!pins.output_enable_n |->
		pins.write_strobe_n) else $error("strobe low in read");
	bus_wr_only_a: assert property ((dq_oe != 0) |->
		!pins.write_strobe_n) else $error("bus driven outside write");
	wr_drive_a: assert property (!pins.write_strobe_n |->
		dq_oe == '1) else $error("write data not driven");
	end_together_a: assert property ($rose(pins.write_strobe_n) |->
		$rose(pins.chip_select_n)) else $error("write end split");
	addr_hold_a: assert property ($fell(pins.write_strobe_n) |=>
		$stable(pins.addr)) else $error("address moved in write");
	rd_answer_a: assert property ($fell(pins.output_enable_n) |->
		##[3:8] rsp_valid) else $error("read answer late");
	ret_desel_a: assert property (retention_ok |->
		pins.chip_select_n && !$past(req_ready)) else $error("retention selected");
endmodule
bind asb_host asb_props asb_props_inst(.clk(clk), .rst(rst),
	.req_ready(req_ready), .rsp_valid(rsp_valid),
	.retention_req(retention_req), .retention_ok(retention_ok),
	.pins(pins), .dq_oe(dq_oe));
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the host controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import asb_pkg::*;
	logic clk = 0;
	logic rst = 1;
	logic req_valid = 0;
	logic retention_req = 0;
	asb_req_s req = '0;
	logic req_ready, rsp_valid, retention_ok;
	logic [DATA_W-1:0] rsp_rdata, dq_out, dq_oe, mq, dq;
	asb_pins_s pins;
	logic [31:0] seed = 32'h0000_0034;
	logic [31:0] expq [$];
	logic [31:0] note;
	int mismatches = 0;
	int checks_done = 0;
	initial begin
		forever #20 clk = ~clk;
	end
	// Wire level from both drivers
	assign dq = (dq_out & dq_oe) | (mq & ~dq_oe);
	asb_host asb_host_inst(.clk(clk), .rst(rst), .req_valid(req_valid),
		.req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata), .retention_req(retention_req),
		.retention_ok(retention_ok), .pins(pins), .dq_in(dq),
		.dq_out(dq_out), .dq_oe(dq_oe));
	asb_mem asb_mem_inst(.pins(pins), .dq(dq), .q(mq));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic cmp(input string n, input logic [15:0] e,
		input logic [15:0] s);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	// One request, held until the controller takes it
	task automatic send(input logic w, input logic [17:0] a,
		input logic [15:0] d, input logic [1:0] l);
		int n;
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{w, a, d, l};
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (req_ready !== 1'b1 && n < 40);
		if (req_ready !== 1'b1) begin
			mismatches++;
			end_sim();
		end
		@(posedge clk);
		req_valid <= 1'b0;
	endtask
	// Each read answer against the oldest note
	always @(posedge clk) begin
		if (rsp_valid === 1'b1 && expq.size() == 0) begin
			mismatches++;
			$display("BAD rsp_valid exp 0 seen 1");
		end else if (rsp_valid === 1'b1) begin
			note = expq.pop_front();
			cmp("rdata", note[15:0], rsp_rdata & note[31:16]);
		end
	end
	initial begin
		logic [17:0] a;
		logic [15:0] d, m;
		logic [1:0] l;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		cmp("cs_idle", 16'h0001, {15'h0000, pins.chip_select_n});
		// Full write, lane-masked write, full and masked reads
		for (int i = 0; i < 16; i++) begin
			seed = xs(seed);
			a = seed[17:0];
			d = seed[31:16];
			l = i[1:0];
			m = {{8{~l[1]}}, {8{~l[0]}}};
			send(1'b1, a, ~d, 2'h0);
			send(1'b1, a, d, l);
			expq.push_back({16'hffff, (d & m) | (~d & ~m)});
			send(1'b0, a, 16'h0000, 2'h0);
			expq.push_back({m, d & m});
			send(1'b0, a, 16'h0000, l);
		end
		for (int n = 0; n < 40 && expq.size() > 0; n++) @(posedge clk);
		if (expq.size() > 0) mismatches++;
		$display("test lanes done");
		retention_req <= 1'b1;
		repeat (4) @(posedge clk);
		cmp("ret_ok", 16'h0001, {15'h0000, retention_ok});
		cmp("ready", 16'h0000, {15'h0000, req_ready});
		retention_req <= 1'b0;
		$display("test retention done");
		end_sim();
	end
endmodule
`default_nettype wire

// [verilog/asb_host.sv]
// Host controller driving an async static memory with byte lanes
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Write starts with both low, ends when either rises.
// - Data set-up and hold timed to the write-ending edge.
// - Address stable at least address-to-write-end before write ends.
// - Address may change at the write-ending edge.
// - Address valid no later than the write-starting edge.
// - Write data set up before write end; zero hold needed.
// - Lane select held at least lane-to-write-end before write end.
// - Strobe-ended write with enable low needs float plus set-up.
// - Read keeps strobe high, address valid by chip select fall.
module asb_host
	import asb_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic req_valid,
	output logic req_ready,
	input wire asb_req_s req,
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_rdata,
	input wire logic retention_req,
	output logic retention_ok,
	output asb_pins_s pins,
	input wire logic [DATA_W-1:0] dq_in,
	output logic [DATA_W-1:0] dq_out,
	output logic [DATA_W-1:0] dq_oe
);
	asb_state_e state_ff, nxt_state;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	asb_pins_s pins_ff;
	logic [DATA_W-1:0] wdata_ff;
	logic drive_ff;
	logic [DATA_W-1:0] rd_s1_ff, rd_s2_ff, rd_s3_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic rsp_ff;
	logic accept;

	// Idle only; no queue, so requests wait here
	assign req_ready = (state_ff == ASB_IDLE) && !retention_req;
	assign accept = req_valid && req_ready;

	// Next state; read data must settle through the sampler too
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		case (state_ff)
			ASB_IDLE: begin
				if (accept && req.write) begin
					nxt_state = ASB_WRITE;
					nxt_cnt = CNT_W'(WRITE_CYC);
				end else if (accept) begin
					nxt_state = ASB_READ;
					nxt_cnt = CNT_W'(READ_CYC + 2);
				end
			end
			ASB_READ: begin
				nxt_cnt = cnt_ff - CNT_ONE;
				if (cnt_ff == CNT_ONE) begin
					nxt_state = ASB_RD_DONE;
				end
			end
			ASB_RD_DONE: begin
				nxt_state = ASB_FLOAT;
				nxt_cnt = CNT_W'(FLOAT_CYC);
			end
			ASB_WRITE: begin
				nxt_cnt = cnt_ff - CNT_ONE;
				if (cnt_ff == CNT_ONE) begin
					nxt_state = ASB_WR_END;
				end
			end
			ASB_WR_END: begin
				nxt_state = ASB_FLOAT;
				nxt_cnt = CNT_W'(FLOAT_CYC);
			end
			ASB_FLOAT: begin
				nxt_cnt = cnt_ff - CNT_ONE;
				if (cnt_ff == CNT_ONE) begin
					nxt_state = ASB_IDLE;
				end
			end
			default: begin
				nxt_state = ASB_IDLE;
				nxt_cnt = CNT_ZERO;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_ff <= ASB_IDLE;
			cnt_ff <= CNT_ZERO;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
		end
	end

	// Memory control pins; address and lanes settle with chip select
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pins_ff <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, '0};
		end else begin
			case (nxt_state)
				ASB_READ: begin
					if (state_ff == ASB_IDLE) begin
						pins_ff.addr <= req.addr;
						{pins_ff.high_lane_select_n,
							pins_ff.low_lane_select_n} <= req.lane_n;
					end
					pins_ff.chip_select_n <= 1'b0;
					pins_ff.write_strobe_n <= 1'b1;
					pins_ff.output_enable_n <= 1'b0;
				end
				ASB_WRITE: begin
					if (state_ff == ASB_IDLE) begin
						pins_ff.addr <= req.addr;
						{pins_ff.high_lane_select_n,
							pins_ff.low_lane_select_n} <= req.lane_n;
					end
					pins_ff.chip_select_n <= 1'b0;
					pins_ff.write_strobe_n <= 1'b0;
					pins_ff.output_enable_n <= 1'b1;
				end
				default: begin
					// Strobe and select rise together; address is kept
					pins_ff.chip_select_n <= 1'b1;
					pins_ff.write_strobe_n <= 1'b1;
					pins_ff.output_enable_n <= 1'b1;
					{pins_ff.high_lane_select_n,
						pins_ff.low_lane_select_n} <= LANES_OFF;
				end
			endcase
		end
	end
	assign pins = pins_ff;

	// Data bus driven only during the write pulse; released at its ending edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wdata_ff <= '0;
			drive_ff <= 1'b0;
		end else begin
			if (accept && req.write) begin
				wdata_ff <= req.wdata;
			end
			drive_ff <= (nxt_state == ASB_WRITE);
		end
	end
	assign dq_out = wdata_ff;
	assign dq_oe = drive_ff ? {DATA_W{1'b1}} : '0;

	// Read data sampler; pins are asynchronous to clk
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_s1_ff <= '0;
			rd_s2_ff <= '0;
			rd_s3_ff <= '0;
		end else begin
			rd_s1_ff <= dq_in;
			rd_s2_ff <= rd_s1_ff;
			rd_s3_ff <= rd_s2_ff;
		end
	end

	// Capture only when stages agree, else keep last stable word
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_ff <= '0;
			rsp_ff <= 1'b0;
		end else begin
			rsp_ff <= (state_ff == ASB_RD_DONE);
			// A word that is still moving is not taken; last word stays
			if (state_ff == ASB_RD_DONE && rd_s2_ff == rd_s3_ff) begin
				rdata_ff <= rd_s3_ff;
			end
		end
	end
	assign rsp_valid = rsp_ff;
	assign rsp_rdata = rdata_ff;

	// Retention allowed only once the device sits deselected
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			retention_ok <= 1'b0;
		end else begin
			retention_ok <= retention_req && state_ff == ASB_IDLE &&
				pins_ff.chip_select_n;
		end
	end
endmodule
`default_nettype wire

// [verilog/asb_pkg.sv]
// Package for the async static memory byte-lane host controller
package asb_pkg;
	localparam int ADDR_W = 18;
	localparam int DATA_W = 16;
	localparam int LANE_W = 8;
	// Clock period in ns
	localparam int CLK_PERIOD_NS = 40;
	// Device timing figures in ns, slowest grade
	localparam int ADDR_ACCESS_TIME_NS = 25;
	localparam int OE_ACCESS_NS = 10;
	localparam int LANE_ACCESS_NS = 10;
	localparam int WRITE_PULSE_NS = 15;
	localparam int ADDR_TO_WRITE_END_NS = 15;
	localparam int LANE_TO_WRITE_END_NS = 15;
	localparam int DATA_SETUP_TO_WRITE_END_NS = 10;
	localparam int STROBE_TO_FLOAT_DELAY_NS = 10;
	localparam int OE_TO_FLOAT_NS = 10;
	// Least times round up to whole cycles, never below one
	function automatic int asb_cyc_min(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int READ_CYC = asb_cyc_min(ADDR_ACCESS_TIME_NS);
	localparam int WRITE_CYC = asb_cyc_min(WRITE_PULSE_NS);
	localparam int FLOAT_CYC = asb_cyc_min(OE_TO_FLOAT_NS);
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
	localparam logic [1:0] LANES_OFF = 2'h3;

	typedef enum logic [2:0] {
		ASB_IDLE = 3'b000,
		ASB_READ = 3'b001,
		ASB_RD_DONE = 3'b010,
		ASB_WRITE = 3'b011,
		ASB_WR_END = 3'b100,
		ASB_FLOAT = 3'b101
	} asb_state_e;

	// User request
	typedef struct packed {
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [1:0] lane_n;
	} asb_req_s;

	// Memory pin outputs
	typedef struct packed {
		logic chip_select_n;
		logic output_enable_n;
		logic write_strobe_n;
		logic low_lane_select_n;
		logic high_lane_select_n;
		logic [ADDR_W-1:0] addr;
	} asb_pins_s;
endpackage
